// [logic/rib_pkg.sv]
package rib_pkg;
    // clock
    localparam int unsigned CLK_NS          = 10;
    // initialization phase after any exit from reset
    localparam int unsigned INIT_MS         = 40;
    localparam int unsigned INIT_CYC        = INIT_MS * 1000000 / CLK_NS;
    // least low time on the reset pin that counts as a reset
    localparam int unsigned RST_PULSE_NS    = 1000;
    localparam int unsigned RST_PULSE_CYC   = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    // reset_release_delay: longest time from pin high to leaving reset
    localparam int unsigned REL_DELAY_NS    = 1000;
    localparam int unsigned REL_DELAY_CYC   = REL_DELAY_NS / CLK_NS;
    // cycles spent outside the release count: two sync flops, held flag,
    // entry into release and the final count step
    localparam int unsigned SYNC_LAT        = 5;
    localparam int unsigned REL_WAIT_CYC    = REL_DELAY_CYC - SYNC_LAT;
    // nonvolatile commit of the first fault and of the snapshot log
    localparam int unsigned FIRST_US        = 500;
    localparam int unsigned FIRST_CYC       = FIRST_US * 1000 / CLK_NS;
    localparam int unsigned SNAP_MS         = 4;
    localparam int unsigned SNAP_CYC        = SNAP_MS * 1000000 / CLK_NS;
    // cascade clock pulse width while firmware check keeps failing
    localparam int unsigned FW_PULSE_MS     = 250;
    localparam int unsigned FW_PULSE_CYC    = FW_PULSE_MS * 1000000 / CLK_NS;
    // stored fault-log entries checked one by one
    localparam int unsigned LOG_N           = 8;

    typedef enum logic [2:0] {
        RIB_ST_RESET   = 3'h0,
        RIB_ST_RELEASE = 3'h1,
        RIB_ST_INIT    = 3'h2,
        RIB_ST_RUN     = 3'h3,
        RIB_ST_OFF     = 3'h4
    } rib_state_e;

    typedef enum logic [1:0] {
        RIB_LG_IDLE = 2'h0,
        RIB_LG_EVT  = 2'h1,
        RIB_LG_SNAP = 2'h2
    } rib_log_e;

    // power-up integrity check results
    typedef struct packed {
        logic             fw_ok;
        logic             cfg_ok;
        logic             range_ok;
        logic [LOG_N-1:0] log_ok;
    } rib_chk_s;

    // block status
    typedef struct packed {
        logic in_reset;
        logic init;
        logic run;
        logic cfg_valid;
        logic cfg_err;
        logic brownout;
        logic fw_fail;
    } rib_stat_s;
endpackage : rib_pkg

// [logic/rib_top.sv]
`timescale 1ns/100ps
// What this block does
// [RL1] stay in reset until the digital supply is above the release threshold
// [RL2] reset pin held low longer than the least pulse time forces reset
// [RL3] leave reset within reset_release_delay after the reset pin goes high
// [RL4] every exit from reset starts a 40 ms initialization phase
// [RL5] all I/O high-impedance while initialization runs
// [RL6] after initialization run exactly as the stored configuration says
// [RL7] bad configuration checksum: drop configuration, raise alert and status flag
// [RL8] check each fault-log entry alone, keep the good ones only
// [RL9] supply below brownout_threshold raises a brownout event
// [RL10] during brownout keep committing already captured fault events
// [RL11] below shutdown_threshold shut down; uncommitted faults are lost
// [RL12] first fault commit takes 500 us, snapshot log 4 ms more
// [RL13] bad firmware checksum at power-up resets the device
// [RL14] while firmware keeps failing, cascade clock pulses of 250 ms width
// [RL15] firmware watchdog timeout resets the device
// [RL16] all I/O high-impedance while in reset
// [RL17] every configuration parameter is range checked during recovery
// [RL18] no user configuration: I/O high-impedance, no sequencing, no fault response; fault events are still captured and committed
// [RL19] previous configuration bank erased only after the new one stored well
// [RL20] failed programming keeps the previous bank for the next reset
// [RL21] store-all-defaults copies working memory into nonvolatile configuration
// [RL22] a downloaded configuration image takes effect after the next reset
// [RL23] reset pin release synchronised to the clock before reset ends
module rib_top
    import rib_pkg::*;
#(
    parameter int unsigned INIT_CYCLES  = INIT_CYC,
    parameter int unsigned FIRST_CYCLES = FIRST_CYC,
    parameter int unsigned SNAP_CYCLES  = SNAP_CYC,
    parameter int unsigned FW_CYCLES    = FW_PULSE_CYC,
    parameter int unsigned PEND_W       = 8
) (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    // pins and analog comparators
    input  wire logic             i_ext_rst_n,
    input  wire logic             i_supply_ok,
    input  wire logic             i_brownout,
    input  wire logic             i_shutdown,
    // integrity checks and watchdog
    input  wire logic             i_chk_done,
    input  wire rib_chk_s         i_chk,
    input  wire logic             i_cfg_loaded,
    input  wire logic             i_wdt_timeout,
    // fault logging
    input  wire logic             i_fault_evt,
    // configuration programming
    input  wire logic             i_store_all,
    input  wire logic             i_image_start,
    input  wire logic             i_prog_ok,
    input  wire logic             i_prog_err,
    // outputs
    output logic                  o_io_oe,
    output logic                  o_seq_en,
    output logic                  o_alert,
    output logic                  o_sync_clk,
    output logic [LOG_N-1:0]      o_log_keep,
    output logic                  o_log_commit,
    output logic                  o_log_busy,
    output logic                  o_nv_copy,
    output logic                  o_erase,
    output logic                  o_erase_bank,
    output logic                  o_prog_bank,
    output logic                  o_prog_busy,
    output logic                  o_load_bank,
    output rib_stat_s             o_stat
);

    logic [1:0]        rst_sync;
    logic              rst_n;
    logic [3:0]        pin_meta;
    logic [3:0]        pin_sync;
    logic [31:0]       pin_cnt_reg;
    logic              ext_held_reg;
    rib_state_e        st_reg;
    rib_state_e        st_next;
    logic [31:0]       st_cnt_reg;
    logic              chk_seen_reg;
    logic              fw_fail_reg;
    logic              cfg_valid_reg;
    logic [31:0]       fw_cnt_reg;
    rib_log_e          lg_reg;
    rib_log_e          lg_next;
    logic [31:0]       lg_cnt_reg;
    logic [PEND_W-1:0] pend_reg;
    logic              snap_done_reg;
    logic              active_bank_reg;

    // release of the asynchronous reset
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // two-flop synchronisers for pin and comparator levels
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= {i_ext_rst_n, i_supply_ok, i_brownout, i_shutdown}; // RL23
            pin_sync <= pin_meta;
        end
    end

    wire ext_low   = ~pin_sync[3];
    wire supply_ok = pin_sync[2];
    wire bor       = pin_sync[1];
    wire shdn      = pin_sync[0];

    // short glitches on the reset pin are filtered, not obeyed
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_cnt_reg  <= 32'h0;
            ext_held_reg <= 1'b0;
        end else if (!ext_low) begin
            pin_cnt_reg  <= 32'h0;
            ext_held_reg <= 1'b0;
        end else if (pin_cnt_reg == RST_PULSE_CYC) begin
            ext_held_reg <= 1'b1; // RL2
        end else begin
            pin_cnt_reg <= pin_cnt_reg + 32'h1;
        end
    end

    wire hold_rst  = ~supply_ok | ext_held_reg; // RL1 RL2
    wire chk_take  = (st_reg == RIB_ST_INIT) & i_chk_done & ~chk_seen_reg;
    wire fw_bad    = chk_take & ~i_chk.fw_ok;
    wire wdt_hit   = i_wdt_timeout & ((st_reg == RIB_ST_INIT) | (st_reg == RIB_ST_RUN));
    // a late check result still ends init instead of hanging on an exact count
    wire init_end  = (st_cnt_reg >= INIT_CYCLES - 1) & chk_seen_reg;
    wire cfg_good  = cfg_valid_reg & i_cfg_loaded; // RL18
    wire st_change = st_next != st_reg;

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            RIB_ST_RESET: begin
                if (!hold_rst) st_next = RIB_ST_RELEASE;
            end
            RIB_ST_RELEASE: begin
                if (hold_rst) st_next = RIB_ST_RESET;
                else if (st_cnt_reg == REL_WAIT_CYC) st_next = RIB_ST_INIT; // RL3
            end
            RIB_ST_INIT: begin
                if (hold_rst | wdt_hit | fw_bad) st_next = RIB_ST_RESET; // RL13 RL15
                else if (init_end) st_next = RIB_ST_RUN; // RL4
            end
            RIB_ST_RUN: begin
                if (hold_rst | wdt_hit) st_next = RIB_ST_RESET; // RL15
            end
            RIB_ST_OFF: begin
                if (!shdn) st_next = RIB_ST_RESET;
            end
            default: st_next = RIB_ST_RESET;
        endcase
        if (shdn) st_next = RIB_ST_OFF; // RL11
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg     <= RIB_ST_RESET;
            st_cnt_reg <= 32'h0;
        end else begin
            st_reg     <= st_next;
            st_cnt_reg <= st_change ? 32'h0 : st_cnt_reg + 32'h1;
        end
    end

    // integrity check results, taken once per initialization
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            chk_seen_reg  <= 1'b0;
            cfg_valid_reg <= 1'b0;
            o_alert       <= 1'b0;
            o_log_keep    <= '0;
            fw_fail_reg   <= 1'b0;
        end else if (st_reg == RIB_ST_RESET || st_reg == RIB_ST_OFF) begin
            chk_seen_reg  <= 1'b0;
            cfg_valid_reg <= 1'b0;
        end else if (chk_take) begin
            chk_seen_reg  <= 1'b1;
            cfg_valid_reg <= i_chk.cfg_ok & i_chk.range_ok; // RL7 RL17
            o_alert       <= ~i_chk.cfg_ok; // RL7
            o_log_keep    <= i_chk.log_ok; // RL8
            fw_fail_reg   <= ~i_chk.fw_ok; // RL13
        end
    end

    // I/O driven only in normal operation with a usable configuration
    wire run_next = (st_next == RIB_ST_RUN) & cfg_good & ~shdn;
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_io_oe  <= 1'b0;
            o_seq_en <= 1'b0;
        end else begin
            o_io_oe  <= run_next; // RL5 RL6 RL16 RL18
            o_seq_en <= run_next; // RL18
        end
    end

    // visible heartbeat on the cascade clock while firmware stays broken
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            fw_cnt_reg <= 32'h0;
            o_sync_clk <= 1'b0;
        end else if (!fw_fail_reg) begin
            fw_cnt_reg <= 32'h0;
            o_sync_clk <= 1'b0;
        end else if (fw_cnt_reg == FW_CYCLES - 1) begin
            fw_cnt_reg <= 32'h0;
            o_sync_clk <= ~o_sync_clk; // RL14
        end else begin
            fw_cnt_reg <= fw_cnt_reg + 32'h1;
        end
    end

    // fault log commit: brownout blocks new captures, not pending writes
    wire alive    = st_reg != RIB_ST_OFF;
    wire capture  = i_fault_evt & ~bor & alive & ~shdn; // RL10
    wire evt_end  = (lg_reg == RIB_LG_EVT) & (lg_cnt_reg == FIRST_CYCLES - 1);
    wire snap_end = (lg_reg == RIB_LG_SNAP) & (lg_cnt_reg == SNAP_CYCLES - 1);

    always_comb begin
        lg_next = lg_reg;
        unique case (lg_reg)
            RIB_LG_IDLE: if (pend_reg != '0) lg_next = RIB_LG_EVT;
            RIB_LG_EVT:  if (evt_end) lg_next = snap_done_reg ? RIB_LG_IDLE : RIB_LG_SNAP;
            RIB_LG_SNAP: if (snap_end) lg_next = RIB_LG_IDLE; // RL12
            default:     lg_next = RIB_LG_IDLE;
        endcase
        if (shdn) lg_next = RIB_LG_IDLE; // RL11
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            lg_reg        <= RIB_LG_IDLE;
            lg_cnt_reg    <= 32'h0;
            pend_reg      <= '0;
            snap_done_reg <= 1'b0;
            o_log_commit  <= 1'b0;
            o_log_busy    <= 1'b0;
        end else if (shdn) begin
            lg_reg        <= RIB_LG_IDLE; // RL11
            lg_cnt_reg    <= 32'h0;
            pend_reg      <= '0;
            snap_done_reg <= 1'b0;
            o_log_commit  <= 1'b0;
            o_log_busy    <= 1'b0;
        end else begin
            lg_reg        <= lg_next;
            lg_cnt_reg    <= (lg_next != lg_reg) ? 32'h0 : lg_cnt_reg + 32'h1; // RL12
            pend_reg      <= pend_reg + PEND_W'(capture) - PEND_W'(evt_end);
            o_log_commit  <= evt_end; // RL10
            o_log_busy    <= lg_next != RIB_LG_IDLE;
            if (snap_end) snap_done_reg <= 1'b1;
        end
    end

    // dual-bank configuration store
    wire prog_go = (i_store_all | i_image_start) & ~o_prog_busy & (st_reg == RIB_ST_RUN);
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            active_bank_reg <= 1'b0;
            o_load_bank     <= 1'b0;
            o_prog_busy     <= 1'b0;
            o_prog_bank     <= 1'b1;
            o_nv_copy       <= 1'b0;
            o_erase         <= 1'b0;
            o_erase_bank    <= 1'b0;
        end else begin
            o_nv_copy <= prog_go & i_store_all; // RL21
            o_erase   <= o_prog_busy & i_prog_ok; // RL19
            if (prog_go) begin
                o_prog_busy <= 1'b1;
                o_prog_bank <= ~active_bank_reg;
            end else if (o_prog_busy & i_prog_ok) begin
                o_prog_busy     <= 1'b0;
                active_bank_reg <= o_prog_bank;
                o_erase_bank    <= active_bank_reg; // RL19
            end else if (o_prog_busy & i_prog_err) begin
                o_prog_busy <= 1'b0; // RL20
            end
            // the bank in use changes only across a reset
            if (st_reg == RIB_ST_RESET) o_load_bank <= active_bank_reg; // RL20 RL22
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_stat <= '0;
        end else begin
            o_stat.in_reset  <= (st_next == RIB_ST_RESET) | (st_next == RIB_ST_RELEASE);
            o_stat.init      <= st_next == RIB_ST_INIT;
            o_stat.run       <= st_next == RIB_ST_RUN;
            o_stat.cfg_valid <= cfg_valid_reg;
            o_stat.cfg_err   <= o_alert; // RL7
            o_stat.brownout  <= bor; // RL9
            o_stat.fw_fail   <= fw_fail_reg;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    property p_ext_reset;
        $rose(ext_held_reg) && !shdn |=> st_reg == RIB_ST_RESET;
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("reset pin did not force reset"); // RL2

    property p_init_len;
        $rose(st_reg == RIB_ST_RUN) |->
            $past(st_reg) == RIB_ST_INIT && $past(st_cnt_reg) >= INIT_CYCLES - 1;
    endproperty
    a_init_len: assert property (p_init_len) else $error("run entered early"); // RL4

    property p_io_hiz;
        st_reg != RIB_ST_RUN |-> !o_io_oe && !o_seq_en;
    endproperty
    a_io_hiz: assert property (p_io_hiz) else $error("I/O driven outside run"); // RL16

    property p_cfg_bad;
        chk_take && !i_chk.cfg_ok |=> o_alert && !cfg_valid_reg ##1 o_stat.cfg_err;
    endproperty
    a_cfg_bad: assert property (p_cfg_bad) else $error("bad configuration kept"); // RL7

    sequence s_fw_fail;
        fw_bad && !shdn;
    endsequence
    property p_fw_reset;
        s_fw_fail |=> st_reg == RIB_ST_RESET && fw_fail_reg;
    endproperty
    a_fw_reset: assert property (p_fw_reset) else $error("firmware failure not reset"); // RL13

    property p_wdt;
        wdt_hit && !shdn |=> st_reg == RIB_ST_RESET ##1 !o_io_oe;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog did not reset"); // RL15

    property p_shdn;
        shdn |=> st_reg == RIB_ST_OFF && pend_reg == '0 && !o_log_busy;
    endproperty
    a_shdn: assert property (p_shdn) else $error("shutdown kept state"); // RL11

    property p_erase;
        o_erase |-> $past(i_prog_ok) && o_erase_bank != active_bank_reg;
    endproperty
    a_erase: assert property (p_erase) else $error("erase without good store"); // RL19

    property p_bor_commit;
        lg_reg == RIB_LG_EVT && bor && !shdn && !evt_end |=> lg_reg == RIB_LG_EVT;
    endproperty
    a_bor_commit: assert property (p_bor_commit) else $error("brownout halted commit"); // RL10

    property p_sync_quiet;
        !fw_fail_reg |=> !o_sync_clk;
    endproperty
    a_sync_quiet: assert property (p_sync_quiet) else $error("cascade clock without fault"); // RL14

endmodule : rib_top

// [tb/rib_partner.sv]
`timescale 1ns/100ps
// reset circuit and bus host at the far side of the block
module rib_partner (
    // clock
    input  wire logic        i_mclk,
    // bench commands
    input  wire logic        i_rst_go,
    input  wire logic [15:0] i_rst_len,
    input  wire logic        i_cmd_go,
    input  wire logic        i_cmd_img,
    input  wire logic        i_cmd_bad,
    input  wire logic [7:0]  i_lat,
    // toward the block
    output logic             o_ext_rst_n,
    output logic             o_store_all,
    output logic             o_image_start,
    output logic             o_prog_ok,
    output logic             o_prog_err
);
    int unsigned low_cnt = 0;
    int unsigned lat_cnt = 0;
    logic        bad     = 1'b0;
    initial {o_ext_rst_n, o_store_all, o_image_start, o_prog_ok, o_prog_err} = 5'h10;
    always @(posedge i_mclk) begin
        o_store_all   <= 1'b0;
        o_image_start <= 1'b0;
        o_prog_ok     <= 1'b0;
        o_prog_err    <= 1'b0;
        low_cnt       <= i_rst_go ? i_rst_len : (low_cnt != 0 ? low_cnt - 1 : 0);
        o_ext_rst_n   <= !(i_rst_go || low_cnt > 1);
        if (i_cmd_go) begin
            o_store_all   <= !i_cmd_img;
            o_image_start <= i_cmd_img;
            lat_cnt       <= i_lat + 1;
            bad           <= i_cmd_bad;
        end else if (lat_cnt == 1) begin
            // latency sets a prompt or a slow programming result
            o_prog_ok  <= !bad;
            o_prog_err <= bad;
            lat_cnt    <= 0;
        end else if (lat_cnt != 0) begin
            lat_cnt <= lat_cnt - 1;
        end
    end
endmodule : rib_partner

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
    import rib_pkg::*;
    localparam int unsigned INIT_N = 200;
    localparam int unsigned FIRST_N = 20;
    localparam int unsigned SNAP_N = 50;
    localparam int unsigned FW_N = 30;
    logic i_mclk = 0, i_rst_n = 0, i_supply_ok = 0, i_brownout = 0, i_shutdown = 0;
    logic i_chk_done = 0, i_cfg_loaded = 0, i_wdt_timeout = 0, i_fault_evt = 0;
    logic ext_rst_n, store_all, image_start, prog_ok, prog_err;
    logic p_rst_go = 0, p_go = 0, p_img = 0, p_bad = 0, sc_ref, b;
    logic [15:0] p_len = 0;
    rib_chk_s i_chk = '0, good = '1, c;
    logic o_io_oe, o_seq_en, o_alert, o_sync_clk, o_log_commit, o_log_busy, o_nv_copy;
    logic o_erase, o_erase_bank, o_prog_bank, o_prog_busy, o_load_bank;
    logic [LOG_N-1:0] o_log_keep;
    rib_stat_s o_stat;
    int errors = 0, total_checks = 0, cyc = 0, seed, n, erase_cnt = 0, commit_cnt = 0;

    initial forever #5 i_mclk = ~i_mclk;

    rib_partner i_rib_partner (.i_mclk(i_mclk), .i_rst_go(p_rst_go), .i_rst_len(p_len),
        .i_cmd_go(p_go), .i_cmd_img(p_img), .i_cmd_bad(p_bad), .i_lat(8'h04),
        .o_ext_rst_n(ext_rst_n), .o_store_all(store_all), .o_image_start(image_start),
        .o_prog_ok(prog_ok), .o_prog_err(prog_err));

    rib_top #(.INIT_CYCLES(INIT_N), .FIRST_CYCLES(FIRST_N), .SNAP_CYCLES(SNAP_N),
        .FW_CYCLES(FW_N)) i_rib_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_ext_rst_n(ext_rst_n), .i_supply_ok(i_supply_ok), .i_brownout(i_brownout),
        .i_shutdown(i_shutdown), .i_chk_done(i_chk_done), .i_chk(i_chk),
        .i_cfg_loaded(i_cfg_loaded), .i_wdt_timeout(i_wdt_timeout),
        .i_fault_evt(i_fault_evt), .i_store_all(store_all), .i_image_start(image_start),
        .i_prog_ok(prog_ok), .i_prog_err(prog_err), .o_io_oe(o_io_oe), .o_seq_en(o_seq_en),
        .o_alert(o_alert), .o_sync_clk(o_sync_clk), .o_log_keep(o_log_keep),
        .o_log_commit(o_log_commit), .o_log_busy(o_log_busy), .o_nv_copy(o_nv_copy),
        .o_erase(o_erase), .o_erase_bank(o_erase_bank), .o_prog_bank(o_prog_bank),
        .o_prog_busy(o_prog_busy), .o_load_bank(o_load_bank), .o_stat(o_stat));

    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (o_erase === 1'b1) erase_cnt <= erase_cnt + 1;
        if (o_log_commit === 1'b1) commit_cnt <= commit_cnt + 1;
        if (cyc == 30000) begin
            errors = errors + 1;
            results();
        end
    end

    task results;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task step(input int k);
        repeat (k) @(posedge i_mclk);
    endtask : step

    function automatic logic sig(input int s);
        case (s)
            0: return o_stat.run;
            1: return o_stat.init;
            2: return o_stat.in_reset;
            3: return o_log_commit;
            4: return o_nv_copy;
            5: return o_erase;
            6: return !o_log_busy;
            7: return o_sync_clk !== sc_ref;
            default: return o_stat.brownout;
        endcase
    endfunction : sig

    // bounded wait, n returns the cycles spent
    task wait_on(input int s, input int lim, input string nm);
        n = 0;
        #1;
        while (sig(s) !== 1'b1 && n < lim) begin
            step(1);
            #1;
            n++;
        end
        chk(nm, 1, sig(s));
    endtask : wait_on

    task reset_pin(input int len);
        step(1);
        p_rst_go <= 1'b1;
        p_len    <= len[15:0];
        step(1);
        p_rst_go <= 1'b0;
        step(len + 3);
        #1;
    endtask : reset_pin

    task host(input logic img, input logic bad);
        step(1);
        {p_go, p_img, p_bad} <= {1'b1, img, bad};
        step(1);
        p_go <= 1'b0;
    endtask : host

    task boot(input rib_chk_s k, input logic ld);
        int t0;
        wait_on(1, 400, "init");
        t0 = cyc;
        step(5);
        #1 chk("io_oe_init", 0, o_io_oe);
        step(1);
        {i_chk_done, i_chk, i_cfg_loaded} <= {1'b1, k, ld};
        step(1);
        i_chk_done <= 1'b0;
        step(2);
        #1 chk("log_keep", k.log_ok, o_log_keep);
        chk("alert", !k.cfg_ok, o_alert);
        if (k.fw_ok) begin
            wait_on(0, INIT_N + 20, "run");
            chk("init_len", 1, (cyc - t0 >= INIT_N - 2) && (cyc - t0 <= INIT_N + 2));
            chk("io_oe_run", k.cfg_ok & k.range_ok & ld, o_io_oe);
            chk("seq_en", k.cfg_ok & k.range_ok & ld, o_seq_en);
            chk("cfg_err", !k.cfg_ok, o_stat.cfg_err);
            chk("cfg_valid", k.cfg_ok & k.range_ok, o_stat.cfg_valid);
        end
    endtask : boot

    initial begin
        seed = 69;
        step(8);
        i_rst_n <= 1'b1;
        step(20);
        #1 chk("in_reset", 1, o_stat.in_reset);
        chk("io_oe_rst", 0, o_io_oe);
        step(1);
        i_supply_ok <= 1'b1;
        boot(good, 1'b1);
        $display("test power-up done");
        reset_pin(50);
        chk("short_pulse", 1, o_stat.run);
        reset_pin(150);
        chk("long_pulse", 1, o_stat.in_reset);
        chk("io_oe_rst", 0, o_io_oe);
        wait_on(1, REL_DELAY_CYC + 5, "release");
        chk("release_time", 1, n + 3 <= REL_DELAY_CYC);
        for (int i = 0; i < 5; i++) begin
            c = rib_chk_s'($random(seed));
            c.fw_ok = 1'b1;
            if (i < 3) {c.cfg_ok, c.range_ok} = (i == 0) ? 2'h1 : (i == 1) ? 2'h2 : 2'h3;
            boot(c, (i == 2) ? 1'b0 : (i < 2) ? 1'b1 : 1'($random(seed)));
            reset_pin(150);
        end
        boot(good, 1'b1);
        $display("test checks done");
        step(1);
        i_wdt_timeout <= 1'b1;
        step(1);
        i_wdt_timeout <= 1'b0;
        wait_on(2, 10, "wdt_reset");
        c = good;
        c.fw_ok = 1'b0;
        boot(c, 1'b1);
        wait_on(2, 10, "fw_reset");
        chk("fw_fail", 1, o_stat.fw_fail);
        sc_ref = o_sync_clk;
        wait_on(7, FW_N + 5, "sync_edge");
        sc_ref = o_sync_clk;
        wait_on(7, FW_N + 5, "sync_edge");
        chk("sync_width", 1, n >= FW_N - 1 && n <= FW_N + 1);
        boot(good, 1'b1);
        $display("test resets done");
        host(1'b0, 1'b0);
        wait_on(4, 3, "nv_copy");
        b = 1'b1;
        chk("prog_bank", b, o_prog_bank);
        chk("prog_busy", 1, o_prog_busy);
        wait_on(5, 10, "erase");
        chk("erase_bank", !b, o_erase_bank);
        // the counter takes the pulse on the next edge
        step(1);
        #1 n = erase_cnt;
        host(1'b1, 1'b1);
        step(15);
        chk("no_erase", n, erase_cnt);
        reset_pin(150);
        chk("load_keep", b, o_load_bank);
        boot(good, 1'b1);
        host(1'b1, 1'b0);
        step(15);
        chk("run_bank", b, o_load_bank);
        reset_pin(150);
        chk("load_new", !b, o_load_bank);
        boot(good, 1'b1);
        $display("test banks done");
        step(1);
        i_fault_evt <= 1'b1;
        step(1);
        i_fault_evt <= 1'b0;
        wait_on(3, FIRST_N + 6, "commit");
        chk("first_time", 1, n >= FIRST_N);
        wait_on(6, SNAP_N + 6, "snap_end");
        chk("snap_time", 1, n >= SNAP_N - 2);
        step(1);
        i_fault_evt <= 1'b1;
        step(2);
        {i_fault_evt, i_brownout} <= 2'h1;
        wait_on(8, 5, "brownout");
        wait_on(3, FIRST_N + SNAP_N + 10, "bo_commit");
        step(1);
        i_shutdown <= 1'b1;
        wait_on(6, 5, "shut_idle");
        n = commit_cnt;
        step(FIRST_N + 10);
        chk("lost", n, commit_cnt);
        $display("test log done");
        results();
    end
endmodule : testbench
